// ===== rtl/kbd_level_pkg.sv
// Package of offsets, reset values and constants for the keyboard level interrupt unit
package kbd_level_pkg;
  // ==========================================================================
  // Register offsets (printed offsets are not all multiples of four: index * 4)
  // ==========================================================================
  localparam logic [7:0]  LEVEL_SELECT_IDX   = 8'h9C;
  localparam logic [7:0]  LINE_MASK_IDX      = 8'h9D;
  localparam logic [7:0]  LINE_FLAG_IDX      = 8'h9E;
  localparam logic [7:0]  GLOBAL_ENABLE_IDX  = 8'hB1;
  localparam logic [7:0]  IRQ_STATUS_IDX     = 8'hC0;
  localparam logic [7:0]  IRQ_CLEAR_IDX      = 8'hC1;
  localparam logic [7:0]  IRQ_ENABLE_IDX     = 8'hC2;
  localparam logic [7:0]  VECTOR_IDX         = 8'hC3;
  localparam int          ADDR_W             = 12;
  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int          GLOBAL_ENABLE_BIT  = 0;
  localparam int          STAT_DETECT_BIT    = 0;
  localparam int          STAT_WAKE_BIT      = 1;
  localparam int          STAT_W             = 2;
  localparam logic [7:0]  LINE_RESET         = 8'h00;
  localparam logic [15:0] KBD_VECTOR         = 16'h003B;
  localparam int          NUM_LINES          = 8;
endpackage

// ===== rtl/keyboard_level_interrupt.sv
// Keyboard level interrupt unit with APB register slave
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Eight keyboard inputs on port one each raise an interrupt on a high or low level.
// - All lines are independent sources sharing one vector at code address 003Bh.
// - One global keypad enable bit gates the combined keyboard request for all lines.
// - Each line compares its pin with the level its select bit picks and reports a match.
// - A detection on line n sets bit n of the line flag register at 9Eh.
// - A set flag requests an interrupt only when its line mask bit at 9Dh is set.
// - A software read of the line flag register clears the flag bits.
// - A line detection can wake the device from idle and power-down.
// - After reset all eight line flag bits read zero.
// - One to eight lines may be used; unused pins stay free for other uses.
// - A clear mask bit leaves its pin a standard I/O pin; a set bit lets its flag request.
// - In the level select register at 9Ch a clear bit picks low, a set bit picks high.
module keyboard_level_interrupt #(
  parameter int LINES = 8                         // Keyboard lines in use, 1 to 8
) (
  input  wire  logic        CORE_CLK,             // System clock, 125 MHz
  input  wire  logic        RST,                  // Async reset, active high
  input  wire  logic [11:0] PADDR,                // APB byte address
  input  wire  logic        PSEL,                 // APB select
  input  wire  logic        PENABLE,              // APB access phase
  input  wire  logic        PWRITE,               // APB direction
  input  wire  logic [31:0] PWDATA,               // APB write data
  output logic       [31:0] PRDATA,               // APB read data
  output logic              PREADY,               // APB ready
  output logic              PSLVERR,              // APB error, unmapped address
  input  wire  logic [7:0]  PORT_ONE,             // Port one pin levels
  output logic       [7:0]  PORT_ONE_KEY_SEL,     // Line serves the keypad, not I/O
  output logic              KEYPAD_IRQ_REQUEST,   // Shared keyboard request, vector 003Bh
  output logic       [15:0] KEYPAD_VECTOR,        // Vector address of the request
  output logic              WAKE_REQUEST,         // Wake from idle or power-down
  output logic              IRQ                   // Block interrupt, level
);
  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  if (LINES < 1 || LINES > kbd_level_pkg::NUM_LINES) begin : g_bad_lines
    $error("LINES must lie between 1 and 8");
  end

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  logic [7:0]  level_select_reg;
  logic [7:0]  line_mask_reg;
  logic [7:0]  line_flag_reg;
  logic [7:0]  line_flag_next;
  logic        global_enable_reg;
  logic [1:0]  irq_status_reg;
  logic [1:0]  irq_enable_reg;
  logic [7:0]  detect;
  logic [7:0]  used_lines;
  logic        wr_acc;
  logic        rd_acc;
  logic        flag_read;
  logic        mapped;

  // Setup cycle answers in one access cycle: ready is held high
  assign wr_acc    = PSEL && PENABLE && PWRITE;
  assign rd_acc    = PSEL && PENABLE && !PWRITE;
  assign flag_read = rd_acc && hit(PADDR, kbd_level_pkg::LINE_FLAG_IDX);
  assign mapped    = hit(PADDR, kbd_level_pkg::LEVEL_SELECT_IDX)
                  || hit(PADDR, kbd_level_pkg::LINE_MASK_IDX)
                  || hit(PADDR, kbd_level_pkg::LINE_FLAG_IDX)
                  || hit(PADDR, kbd_level_pkg::GLOBAL_ENABLE_IDX)
                  || hit(PADDR, kbd_level_pkg::IRQ_STATUS_IDX)
                  || hit(PADDR, kbd_level_pkg::IRQ_CLEAR_IDX)
                  || hit(PADDR, kbd_level_pkg::IRQ_ENABLE_IDX)
                  || hit(PADDR, kbd_level_pkg::VECTOR_IDX);

  // ==========================================================================
  // Per-line level detection
  // ==========================================================================
  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_line
      // Unused lines never detect, so their pins stay free
      assign used_lines[n] = (n < LINES);
      // Low select matches a 0 pin, high select matches a 1 pin
      assign detect[n] = used_lines[n]
                      && (PORT_ONE[n] == level_select_reg[n]);
    end
  endgenerate

  // Flag update: read clears, but a detection in that cycle keeps its bit.
  // Only the bits reported by this read are cleared: a flag set between the
  // setup edge and the access edge was never seen by software, so it stays.
  always_comb begin
    line_flag_next = line_flag_reg;
    if (flag_read) begin
      line_flag_next = line_flag_reg & ~PRDATA[7:0];
    end
    line_flag_next = line_flag_next | detect;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Configuration registers written by software
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      level_select_reg  <= kbd_level_pkg::LINE_RESET;
      line_mask_reg     <= kbd_level_pkg::LINE_RESET;
      global_enable_reg <= 1'b0;
      irq_enable_reg    <= 2'b00;
    end else if (wr_acc) begin
      if (hit(PADDR, kbd_level_pkg::LEVEL_SELECT_IDX)) begin
        level_select_reg <= PWDATA[7:0];
      end
      if (hit(PADDR, kbd_level_pkg::LINE_MASK_IDX)) begin
        line_mask_reg <= PWDATA[7:0];
      end
      if (hit(PADDR, kbd_level_pkg::GLOBAL_ENABLE_IDX)) begin
        global_enable_reg <= PWDATA[kbd_level_pkg::GLOBAL_ENABLE_BIT];
      end
      if (hit(PADDR, kbd_level_pkg::IRQ_ENABLE_IDX)) begin
        irq_enable_reg <= PWDATA[1:0];
      end
    end
  end

  // Line flags, cleared by reset
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      line_flag_reg <= kbd_level_pkg::LINE_RESET;
    end else begin
      line_flag_reg <= line_flag_next;
    end
  end

  // Sticky event status; a new event beats a clear written at the same edge
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      irq_status_reg <= 2'b00;
    end else begin
      irq_status_reg <= (wr_acc && hit(PADDR, kbd_level_pkg::IRQ_CLEAR_IDX))
                      ? (irq_status_reg & ~PWDATA[1:0]) : irq_status_reg;
      if (|detect) begin
        irq_status_reg[kbd_level_pkg::STAT_DETECT_BIT] <= 1'b1;
      end
      if (|(detect & line_mask_reg)) begin
        irq_status_reg[kbd_level_pkg::STAT_WAKE_BIT] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Outputs, all registered
  // ==========================================================================
  // Request is taken from the next flag value, so it changes at the same edge as the flags; shared vector for every line
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      KEYPAD_IRQ_REQUEST <= 1'b0;
      KEYPAD_VECTOR      <= kbd_level_pkg::KBD_VECTOR;
      PORT_ONE_KEY_SEL   <= kbd_level_pkg::LINE_RESET;
      WAKE_REQUEST       <= 1'b0;
      IRQ                <= 1'b0;
    end else begin
      KEYPAD_IRQ_REQUEST <= global_enable_reg
                         && |(line_flag_next & line_mask_reg);
      KEYPAD_VECTOR      <= kbd_level_pkg::KBD_VECTOR;
      PORT_ONE_KEY_SEL   <= line_mask_reg & used_lines;
      // Wake is not gated by the global enable so a sleeping core still wakes
      WAKE_REQUEST       <= |(detect & line_mask_reg);
      IRQ                <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  // Read value of one register; unused upper bits and write-only words read 0
  function automatic logic [31:0] read_value(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a[11:10] == 2'b00 && a[1:0] == 2'b00) begin
      case (a[9:2])
        kbd_level_pkg::LEVEL_SELECT_IDX: begin
          v[7:0] = level_select_reg;
        end
        kbd_level_pkg::LINE_MASK_IDX: begin
          v[7:0] = line_mask_reg;
        end
        kbd_level_pkg::LINE_FLAG_IDX: begin
          v[7:0] = line_flag_reg;
        end
        kbd_level_pkg::GLOBAL_ENABLE_IDX: begin
          v[kbd_level_pkg::GLOBAL_ENABLE_BIT] = global_enable_reg;
        end
        kbd_level_pkg::IRQ_STATUS_IDX: begin
          v[1:0] = irq_status_reg;
        end
        kbd_level_pkg::IRQ_ENABLE_IDX: begin
          v[1:0] = irq_enable_reg;
        end
        kbd_level_pkg::VECTOR_IDX: begin
          v[15:0] = KEYPAD_VECTOR;
        end
        default: begin
          v = 32'h0000_0000;
        end
      endcase
    end
    read_value = v;
  endfunction

  // APB read data and answer; PREADY stays high, so every access ends at once.
  // Data is latched at the setup edge so it stands for the whole access phase.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= 1'b1;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      PRDATA  <= 32'h0000_0000;
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= read_value(PADDR);
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  chk_flag_sets: assert property (@(posedge CORE_CLK) disable iff (RST)
    detect[0] |=> line_flag_reg[0]) else $error("Line 0 detection did not set flag");
  chk_read_clears: assert property (@(posedge CORE_CLK) disable iff (RST)
    (flag_read && detect == 8'h00 && PRDATA[7:0] == line_flag_reg)
    |=> line_flag_reg == 8'h00)
    else $error("Flag read did not clear flags");
  chk_set_wins: assert property (@(posedge CORE_CLK) disable iff (RST)
    (flag_read && detect[3]) |=> line_flag_reg[3]) else $error("Detection lost on read");
  chk_req_mask: assert property (@(posedge CORE_CLK) disable iff (RST)
    KEYPAD_IRQ_REQUEST |-> $past(|(line_flag_next & line_mask_reg)))
    else $error("Request without enabled flag");
  chk_global_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
    !global_enable_reg ##1 !$past(global_enable_reg) |-> !KEYPAD_IRQ_REQUEST)
    else $error("Request while globally disabled");
  chk_level_match: assert property (@(posedge CORE_CLK) disable iff (RST)
    (PORT_ONE[0] != level_select_reg[0]) |-> !detect[0]) else $error("False detection");
  chk_wake_level: assert property (@(posedge CORE_CLK) disable iff (RST)
    (detect[1] && line_mask_reg[1]) |=> WAKE_REQUEST) else $error("No wake on detection");
  chk_vector_fixed: assert property (@(posedge CORE_CLK) disable iff (RST)
    KEYPAD_VECTOR == 16'h003B) else $error("Vector changed");
  chk_reset_flags: assert property (@(posedge CORE_CLK)
    $fell(RST) |-> line_flag_reg == 8'h00) else $error("Flags not zero after reset");
  chk_unused_line: assert property (@(posedge CORE_CLK) disable iff (RST)
    !used_lines[7] |-> !detect[7]) else $error("Unused line detected");
  chk_io_select: assert property (@(posedge CORE_CLK) disable iff (RST)
    !line_mask_reg[2] |=> !PORT_ONE_KEY_SEL[2]) else $error("Pin not freed as I/O");
  chk_high_sel: assert property (@(posedge CORE_CLK) disable iff (RST)
    (level_select_reg[4] && PORT_ONE[4] && used_lines[4]) |-> detect[4])
    else $error("High level missed");

  // Per-line checks, one set for each of the eight lines
  for (genvar k = 0; k < kbd_level_pkg::NUM_LINES; k++) begin : g_line_chk
    if (k < LINES) begin : g_used
      // A line in use detects exactly when its pin equals its chosen level
      chk_line_match: assert property (@(posedge CORE_CLK) disable iff (RST)
        detect[k] == (PORT_ONE[k] == level_select_reg[k]))
        else $error("Line detection differs from its level match");
      // A detection on the line sets that line's own flag
      chk_line_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
        detect[k] |=> line_flag_reg[k]) else $error("Line detection did not set its flag");
      // A set mask bit hands the pin to the keypad one edge later
      chk_line_keysel: assert property (@(posedge CORE_CLK) disable iff (RST)
        line_mask_reg[k] |=> PORT_ONE_KEY_SEL[k]) else $error("Masked-in line not selected");
    end else begin : g_free
      // A line left out never detects and never leaves standard I/O
      chk_line_free: assert property (@(posedge CORE_CLK) disable iff (RST)
        !detect[k] && !PORT_ONE_KEY_SEL[k]) else $error("Unused line is active");
    end
  end

  // A flag never drops unless the flag register is read
  chk_flag_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
    !flag_read |=> (line_flag_reg & $past(line_flag_reg)) == $past(line_flag_reg))
    else $error("Flag dropped without a read");

  // An enabled, unmasked flag raises the shared request at the next edge
  chk_req_on: assert property (@(posedge CORE_CLK) disable iff (RST)
    (global_enable_reg && |(line_flag_next & line_mask_reg)) |=> KEYPAD_IRQ_REQUEST)
    else $error("Enabled flag gave no request");

  // The global enable bit stores the written bit
  chk_global_store: assert property (@(posedge CORE_CLK) disable iff (RST)
    (wr_acc && hit(PADDR, kbd_level_pkg::GLOBAL_ENABLE_IDX))
    |=> global_enable_reg == $past(PWDATA[kbd_level_pkg::GLOBAL_ENABLE_BIT]))
    else $error("Global enable not stored");

  // No masked-in detection, no wake
  chk_wake_quiet: assert property (@(posedge CORE_CLK) disable iff (RST)
    !(|(detect & line_mask_reg)) |=> !WAKE_REQUEST) else $error("Wake without detection");

  // Zero wait states: every access phase is answered at once
  chk_ready_high: assert property (@(posedge CORE_CLK) disable iff (RST)
    (PSEL && PENABLE) |-> PREADY) else $error("Access phase not ready");

  // Error flag in the access phase marks exactly the unmapped addresses
  chk_err_unmapped: assert property (@(posedge CORE_CLK) disable iff (RST)
    (PSEL && PENABLE) |-> (PSLVERR == !mapped)) else $error("Wrong error response");

  // A write to an unmapped address leaves the configuration alone
  chk_write_ignored: assert property (@(posedge CORE_CLK) disable iff (RST)
    (wr_acc && !mapped) |=> $stable(level_select_reg) && $stable(line_mask_reg))
    else $error("Unmapped write changed a register");

  // Read data stands only for a read access; otherwise it is zero
  chk_rdata_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
    !PSEL |=> PRDATA == 32'h0000_0000) else $error("Read data not zero when idle");

  // Any detection sets the sticky detect status bit
  chk_status_detect: assert property (@(posedge CORE_CLK) disable iff (RST)
    (|detect) |=> irq_status_reg[kbd_level_pkg::STAT_DETECT_BIT])
    else $error("Detect status not set");

  // Status stays set until a clear write
  chk_status_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
    (irq_status_reg[kbd_level_pkg::STAT_DETECT_BIT]
     && !(wr_acc && hit(PADDR, kbd_level_pkg::IRQ_CLEAR_IDX)))
    |=> irq_status_reg[kbd_level_pkg::STAT_DETECT_BIT])
    else $error("Status bit dropped without a clear");

  // Block interrupt follows enabled status one edge later
  chk_irq_level: assert property (@(posedge CORE_CLK) disable iff (RST)
    (|(irq_status_reg & irq_enable_reg)) |=> IRQ) else $error("Enabled status gave no IRQ");

  // Main scenarios
  cov_request: cover property (@(posedge CORE_CLK) disable iff (RST) $rose(KEYPAD_IRQ_REQUEST));
  cov_read_race: cover property (@(posedge CORE_CLK) disable iff (RST) flag_read && |detect);
  cov_wake: cover property (@(posedge CORE_CLK) disable iff (RST) $rose(WAKE_REQUEST));
  cov_unmapped: cover property (@(posedge CORE_CLK) disable iff (RST) PSEL && PENABLE && !mapped);
endmodule
`default_nettype wire

// ===== tb/kbd_matrix_model.sv
// Keyboard matrix model that drives the port one lines
`timescale 1ns/1ps
`default_nettype none
module kbd_matrix_model (
  input  wire logic [7:0] KEY_DOWN,  // One bit per pressed key
  output logic      [7:0] PORT_ONE   // Line levels seen by the unit
);
  // ==========================================================================
  // Line levels
  // ==========================================================================
  // Pull-ups hold open lines high, so only a pressed key pulls a line low
  assign PORT_ONE = ~KEY_DOWN;
endmodule
`default_nettype wire

// ===== tb/tb_keyboard_level_interrupt.sv
// Self-checking testbench for the keyboard level interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_keyboard_level_interrupt;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, key_irq, wake, irq, rerr, rdy;
  logic [7:0]  key_down = 8'h00, port_one, key_sel;
  logic [15:0] vec;
  int          mismatches = 0;
  int          cmp_count = 0;
  // Clock at 125 MHz
  always #4 core_clk = ~core_clk;
  kbd_matrix_model kbd_matrix_model_i (.KEY_DOWN(key_down), .PORT_ONE(port_one));
  keyboard_level_interrupt #(.LINES(8)) keyboard_level_interrupt_i (
    .CORE_CLK(core_clk), .RST(rst), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PORT_ONE(port_one), .PORT_ONE_KEY_SEL(key_sel),
    .KEYPAD_IRQ_REQUEST(key_irq), .KEYPAD_VECTOR(vec), .WAKE_REQUEST(wake), .IRQ(irq));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; ready, data and error are taken at the rising edge
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    paddr <= {2'b00, idx, 2'b00};
    psel <= 1'b1;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      rdy = pready;
      rdata = prdata;
      rerr = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 16);
    if (rdy !== 1'b1) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string name);
    apb(idx, 1'b0, 32'h0);
    check(name, rdata, exp);
  endtask
  // Keys change after an edge; outputs are looked at two edges later
  task automatic press(input logic [7:0] v);
    @(posedge core_clk);
    key_down <= v;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(kbd_level_pkg::LINE_FLAG_IDX, 32'h0, "flags_reset");
    rd(kbd_level_pkg::VECTOR_IDX, 32'h3B, "vector_reg");
    check("vector_pin", {16'h0, vec}, {16'h0, kbd_level_pkg::KBD_VECTOR});
    rd(8'h10, 32'h0, "unmapped_data");
    check("unmapped_err", {31'h0, rerr}, 32'h1);
    apb(kbd_level_pkg::LINE_MASK_IDX, 1'b1, 32'hFF);
    apb(kbd_level_pkg::GLOBAL_ENABLE_IDX, 1'b1, 32'h1);
    rd(kbd_level_pkg::LINE_MASK_IDX, 32'hFF, "mask_rw");
    // Low level on each line in turn sets only that line's flag
    for (int i = 0; i < 8; i++) begin
      press(8'h01 << i);
      check("req_low", {31'h0, key_irq}, 32'h1);
      check("wake", {31'h0, wake}, 32'h1);
      press(8'h00);
      rd(kbd_level_pkg::LINE_FLAG_IDX, 32'h1 << i, "flag_line");
      rd(kbd_level_pkg::LINE_FLAG_IDX, 32'h0, "flag_clear");
    end
    // High level select: a pressed key is no match, a released one is
    press(8'h80);
    apb(kbd_level_pkg::LEVEL_SELECT_IDX, 1'b1, 32'h80);
    apb(kbd_level_pkg::LINE_FLAG_IDX, 1'b0, 32'h0);
    rd(kbd_level_pkg::LINE_FLAG_IDX, 32'h0, "high_no_match");
    press(8'h00);
    rd(kbd_level_pkg::LINE_FLAG_IDX, 32'h80, "high_match");
    rd(kbd_level_pkg::LINE_FLAG_IDX, 32'h80, "detect_wins");
    apb(kbd_level_pkg::LEVEL_SELECT_IDX, 1'b1, 32'h0);
    apb(kbd_level_pkg::LINE_FLAG_IDX, 1'b0, 32'h0);
    // Line mask and global enable gate the shared request
    apb(kbd_level_pkg::LINE_MASK_IDX, 1'b1, 32'h0);
    press(8'h01);
    check("req_masked", {31'h0, key_irq}, 32'h0);
    check("sel_io", {24'h0, key_sel}, 32'h0);
    apb(kbd_level_pkg::LINE_MASK_IDX, 1'b1, 32'h1);
    repeat (2) @(negedge core_clk);
    check("req_unmasked", {31'h0, key_irq}, 32'h1);
    check("sel_key", {24'h0, key_sel}, 32'h1);
    apb(kbd_level_pkg::GLOBAL_ENABLE_IDX, 1'b1, 32'h0);
    repeat (2) @(negedge core_clk);
    check("req_global_off", {31'h0, key_irq}, 32'h0);
    // Block interrupt: raise, read status, clear, then mask
    apb(kbd_level_pkg::IRQ_ENABLE_IDX, 1'b1, 32'h1);
    repeat (2) @(negedge core_clk);
    check("irq_on", {31'h0, irq}, 32'h1);
    rd(kbd_level_pkg::IRQ_STATUS_IDX, 32'h3, "irq_status");
    press(8'h00);
    apb(kbd_level_pkg::IRQ_CLEAR_IDX, 1'b1, 32'h3);
    rd(kbd_level_pkg::IRQ_STATUS_IDX, 32'h0, "status_cleared");
    check("irq_off", {31'h0, irq}, 32'h0);
    apb(kbd_level_pkg::IRQ_ENABLE_IDX, 1'b1, 32'h0);
    press(8'h02);
    check("irq_masked", {31'h0, irq}, 32'h0);
    close_out();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(8 * 6000);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
